//--- design/protection_switch.sv
// Purpose: 1+1 connection and section protection selectors
// Assumes: all inputs synchronous to mclk, 100 MHz
// Notes: registers on a plain strobe port, read data one cycle later
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
`include "protsw_defines.svh"
module protection_switch #(
  parameter int TRIB_W = 63,
  parameter int DEG_WINDOW_CYC = `DEG_WINDOW_CYC,
  parameter int THR_W = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input protsw_pkg::reg_req_s reg_req,
  output logic [31:0] rd_data,
  input protsw_pkg::conn_alarm_s conn_alarm_a,
  input protsw_pkg::conn_alarm_s conn_alarm_b,
  input wire logic [1:0] conn_rx_in,
  input wire logic conn_tx_in,
  output logic [1:0] conn_tx_out,
  output logic conn_rx_out,
  output protsw_pkg::member_e conn_active,
  input protsw_pkg::sect_alarm_s sect_alarm_a,
  input protsw_pkg::sect_alarm_s sect_alarm_b,
  input wire logic [1:0] sect_bip_err,
  input wire logic [TRIB_W-1:0] sect_trib_a,
  input wire logic [TRIB_W-1:0] sect_trib_b,
  output logic [TRIB_W-1:0] sect_trib_out,
  input wire logic sect_tx_in,
  output logic [1:0] sect_tx_out,
  output protsw_pkg::member_e sect_active,
  output logic [1:0] unit_intercommunication_bus
);
  localparam int WIN_W = $clog2(DEG_WINDOW_CYC + 1);
  localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(DEG_WINDOW_CYC - 1);

  logic [1:0] ctrl_reg;
  logic [THR_W-1:0] degrade_thr_reg;
  logic [3:0] event_reg;
  logic [WIN_W-1:0] win_cnt_reg;
  logic win_tick_reg;
  logic conn_req;
  logic sect_req;
  logic [1:0] conn_fail_flag;
  logic [1:0] conn_degrade_flag;
  logic [1:0] sect_fail_flag;
  logic [1:0] sect_degrade_flag;
  logic conn_sw;
  logic conn_ref;
  logic sect_sw;
  logic sect_ref;
  logic [1:0] conn_fail;
  logic [1:0] sect_fail;
  logic [31:0] rd_next;
  logic conn_sel;
  logic sect_sel;

  // ==========================================================
  // command decode: a write to the command word is a one-shot request
  assign conn_req = reg_req.wr && (reg_req.addr == `OFS_CMD) &&
                    reg_req.wdata[`CMD_CONN_SW];
  assign sect_req = reg_req.wr && (reg_req.addr == `OFS_CMD) &&
                    reg_req.wdata[`CMD_SECT_SW];

  // ==========================================================
  // failure criteria per group
  // loss or AIS only; AIS from far nodes arrives as a plain alarm
  assign conn_fail[0] = conn_alarm_a.los | conn_alarm_a.ais;
  assign conn_fail[1] = conn_alarm_b.los | conn_alarm_b.ais;
  // local equipment failure folded into the failure flag
  assign sect_fail[0] = |sect_alarm_a;
  assign sect_fail[1] = |sect_alarm_b;

  // ==========================================================
  // degrade window divider
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      win_cnt_reg <= '0;
      win_tick_reg <= 1'b0;
    end else if (win_cnt_reg == WIN_LAST) begin
      win_cnt_reg <= '0;
      win_tick_reg <= 1'b1;
    end else begin
      win_cnt_reg <= win_cnt_reg + 1'b1;
      win_tick_reg <= 1'b0;
    end
  end

  // ==========================================================
  // two separate groups, no shared switching state
  group_selector #(
    .USE_DEGRADE(1'b0),
    .CNT_W(THR_W)
  ) u_conn (
    .mclk(mclk),
    .rst_n(rst_n),
    .auto_mode(ctrl_reg[`CTRL_CONN_AUTO]),
    .sw_req(conn_req),
    .fail_in(conn_fail),
    .bip_err(2'h0),
    .window_tick(win_tick_reg),
    .degrade_thresh(degrade_thr_reg),
    .active_reg(conn_active),
    .signal_failure_flag_reg(conn_fail_flag),
    .signal_degrade_flag_reg(conn_degrade_flag),
    .switched_reg(conn_sw),
    .refused_reg(conn_ref)
  );

  group_selector #(
    .USE_DEGRADE(1'b1),
    .CNT_W(THR_W)
  ) u_sect (
    .mclk(mclk),
    .rst_n(rst_n),
    .auto_mode(ctrl_reg[`CTRL_SECT_AUTO]),
    .sw_req(sect_req),
    .fail_in(sect_fail),
    .bip_err(sect_bip_err),
    .window_tick(win_tick_reg),
    .degrade_thresh(degrade_thr_reg),
    .active_reg(sect_active),
    .signal_failure_flag_reg(sect_fail_flag),
    .signal_degrade_flag_reg(sect_degrade_flag),
    .switched_reg(sect_sw),
    .refused_reg(sect_ref)
  );

  // ==========================================================
  // traffic path
  assign conn_sel = conn_active;
  assign sect_sel = sect_active;

  // transmit bridged to both members, whatever the selectors do
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      conn_tx_out <= 2'h0;
      sect_tx_out <= 2'h0;
    end else begin
      conn_tx_out <= {2{conn_tx_in}};
      sect_tx_out <= {2{sect_tx_in}};
    end
  end

  // receive picks the active member; transmit is never steered by it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      conn_rx_out <= 1'b0;
      sect_trib_out <= '0;
    end else begin
      conn_rx_out <= conn_rx_in[conn_sel];
      sect_trib_out <= sect_sel ? sect_trib_b : sect_trib_a;
    end
  end

  // partner unit told which unit is active and whether it has failed
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      unit_intercommunication_bus <= 2'h0;
    end else begin
      unit_intercommunication_bus <= {sect_fail_flag[sect_sel], sect_sel};
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_reg <= `CTRL_RST;
      degrade_thr_reg <= `DEG_THR_RST;
    end else if (reg_req.wr) begin
      if (reg_req.addr == `OFS_CTRL) begin
        ctrl_reg <= reg_req.wdata[1:0];
      end
      if (reg_req.addr == `OFS_DEG_THR) begin
        degrade_thr_reg <= reg_req.wdata[THR_W-1:0];
      end
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      event_reg <= 4'h0;
    end else begin
      event_reg <= (event_reg &
                    ~((reg_req.wr && (reg_req.addr == `OFS_EVENT)) ?
                      reg_req.wdata[3:0] : 4'h0)) |
                   {sect_ref, conn_ref, sect_sw, conn_sw};
    end
  end

  // ==========================================================
  // read mux; unmapped offsets read as zero
  always_comb begin
    rd_next = 32'h0;
    unique case (reg_req.addr)
      `OFS_CTRL: rd_next[1:0] = ctrl_reg;
      `OFS_STATUS: rd_next[7:0] = {sect_degrade_flag, sect_fail_flag,
                                   conn_fail_flag, sect_sel, conn_sel};
      `OFS_EVENT: rd_next[3:0] = event_reg;
      `OFS_DEG_THR: rd_next[THR_W-1:0] = degrade_thr_reg;
      default: rd_next = 32'h0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_data <= 32'h0;
    end else if (reg_req.rd) begin
      rd_data <= rd_next;
    end else begin
      rd_data <= 32'h0; // data valid only in the cycle after the strobe
    end
  end

  // ==========================================================
  // checks
  logic conn_act_bad;
  logic conn_pas_bad;
  logic sect_act_bad;
  logic sect_pas_bad;
  assign conn_act_bad = conn_fail_flag[conn_sel];
  assign conn_pas_bad = conn_fail_flag[~conn_sel];
  assign sect_act_bad = sect_fail_flag[sect_sel] |
                        sect_degrade_flag[sect_sel];
  assign sect_pas_bad = sect_fail_flag[~sect_sel] |
                        sect_degrade_flag[~sect_sel];

  sequence sect_fault_s;
    ctrl_reg[`CTRL_SECT_AUTO] && !sect_req && sect_act_bad &&
    !sect_pas_bad;
  endsequence

  sequence conn_refuse_s;
    ctrl_reg[`CTRL_CONN_AUTO] && conn_req && conn_pas_bad;
  endsequence

  conn_bridge_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) |-> conn_tx_out == {2{$past(conn_tx_in)}})
    else $error("connection transmit not bridged");

  sect_bridge_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) |-> sect_tx_out == {2{$past(sect_tx_in)}})
    else $error("section transmit not bridged");

  conn_select_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) |-> conn_rx_out == $past(conn_rx_in[conn_sel]))
    else $error("connection output not from active member");

  trib_one_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) |-> sect_trib_out ==
      $past(sect_sel ? sect_trib_b : sect_trib_a))
    else $error("backplane not fed by active unit");

  manual_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !ctrl_reg[`CTRL_SECT_AUTO] && !sect_req |=>
      $stable(sect_active))
    else $error("manual group switched on its own");

  sect_auto_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sect_fault_s |=> sect_active != $past(sect_active) ##0 sect_sw)
    else $error("section did not switch on fault");

  refuse_pass_a: assert property (@(posedge mclk) disable iff (!rst_n)
    conn_refuse_s |=> conn_ref && $stable(conn_active))
    else $error("request with alarmed passive not refused");

  no_revert_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ctrl_reg[`CTRL_CONN_AUTO] && !conn_req && !conn_act_bad |=>
      $stable(conn_active))
    else $error("connection moved with healthy active member");

  both_fail_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ctrl_reg[`CTRL_SECT_AUTO] && !sect_req && sect_act_bad &&
      sect_pas_bad |=> $stable(sect_active))
    else $error("switched with both members failed");

  conn_no_degrade_a: assert property (@(posedge mclk) disable iff (!rst_n)
    conn_degrade_flag == 2'h0)
    else $error("connection group raised degrade");

  sect_fail_map_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) |-> sect_fail_flag[0] == $past(|sect_alarm_a))
    else $error("section failure flag wrong");
endmodule : protection_switch

//--- common/protsw_defines.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 100 MHz mclk, byte addressed register port
// Notes: definitions only
`ifndef PROTSW_DEFINES_SVH
`define PROTSW_DEFINES_SVH
// ==========================================================
// register offsets
`define OFS_CTRL 8'h00
`define OFS_CMD 8'h04
`define OFS_STATUS 8'h08
`define OFS_EVENT 8'h0c
`define OFS_DEG_THR 8'h10
// ==========================================================
// field positions
`define CTRL_CONN_AUTO 0
`define CTRL_SECT_AUTO 1
`define CMD_CONN_SW 0
`define CMD_SECT_SW 1
`define EVT_CONN_SW 0
`define EVT_SECT_SW 1
`define EVT_CONN_REF 2
`define EVT_SECT_REF 3
// ==========================================================
// reset values
`define CTRL_RST 2'h3
`define DEG_THR_RST 16'h0010
// ==========================================================
// timing
`define CLK_PERIOD_NS 10
`define DEG_WINDOW_NS 1000000
`define DEG_WINDOW_CYC (`DEG_WINDOW_NS / `CLK_PERIOD_NS)
`endif

//--- common/protsw_pkg.sv
// Purpose: shared types of the protection selector
// Assumes: nothing
// Notes: constants live in protsw_defines.svh
package protsw_pkg;
  // ==========================================================
  // group members
  typedef enum logic {MEMBER_A = 1'b0, MEMBER_B = 1'b1} member_e;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic los;
    logic ais;
  } conn_alarm_s;
  typedef struct packed {
    logic los;
    logic lof;
    logic ms_ais;
    logic rs_tim;
    logic equip;
  } sect_alarm_s;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
endpackage : protsw_pkg

//--- design/group_selector.sv
// Purpose: one 1+1 group: failure and degrade flags, active member choice
// Assumes: fail_in and bip_err synchronous to mclk
// Notes: non-revertive; degrade only when USE_DEGRADE is set
`timescale 1ns/1ns
module group_selector #(
  parameter bit USE_DEGRADE = 1'b1,
  parameter int CNT_W = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic auto_mode,
  input wire logic sw_req,
  input wire logic [1:0] fail_in,
  input wire logic [1:0] bip_err,
  input wire logic window_tick,
  input wire logic [CNT_W-1:0] degrade_thresh,
  output protsw_pkg::member_e active_reg,
  output logic [1:0] signal_failure_flag_reg,
  output logic [1:0] signal_degrade_flag_reg,
  output logic switched_reg,
  output logic refused_reg
);
  protsw_pkg::member_e active_next;
  logic act;
  logic act_bad;
  logic pas_bad;
  logic go;
  logic refuse;
  logic [CNT_W-1:0] err_cnt [2];

  // ==========================================================
  // failure flags, one cycle behind the alarm pins
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      signal_failure_flag_reg <= 2'h0;
    end else begin
      signal_failure_flag_reg <= fail_in;
    end
  end

  // ==========================================================
  // degrade: parity errors counted per window, judged at its end
  for (genvar i = 0; i < 2; i++) begin : g_deg
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        err_cnt[i] <= '0;
        signal_degrade_flag_reg[i] <= 1'b0;
      end else if (window_tick) begin
        err_cnt[i] <= '0;
        signal_degrade_flag_reg[i] <= USE_DEGRADE &&
          (degrade_thresh != '0) && (err_cnt[i] >= degrade_thresh);
      end else if (bip_err[i] && (err_cnt[i] != '1)) begin
        err_cnt[i] <= err_cnt[i] + 1'b1; // saturates, no wrap
      end
    end
  end

  // ==========================================================
  // switch decision
  always_comb begin
    act = active_reg;
    act_bad = signal_failure_flag_reg[act] |
              signal_degrade_flag_reg[act];
    pas_bad = signal_failure_flag_reg[~act] |
              signal_degrade_flag_reg[~act];
    go = 1'b0;
    refuse = 1'b0;
    if (auto_mode) begin
      if (sw_req && pas_bad) begin
        refuse = 1'b1;
      end else if (sw_req) begin
        go = 1'b1;
      end else if (act_bad && !pas_bad) begin
        go = 1'b1;
      end
    end else begin
      go = sw_req;
    end
  end

  // two members only; recovery never pulls back
  always_comb begin
    active_next = active_reg;
    unique case (active_reg)
      protsw_pkg::MEMBER_A: begin
        if (go) active_next = protsw_pkg::MEMBER_B;
      end
      protsw_pkg::MEMBER_B: begin
        if (go) active_next = protsw_pkg::MEMBER_A;
      end
    endcase
  end

  // ==========================================================
  // state and event pulses
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      active_reg <= protsw_pkg::MEMBER_A;
      switched_reg <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      active_reg <= active_next;
      switched_reg <= go;
      refused_reg <= refuse;
    end
  end
endmodule : group_selector

//--- verif/far_end_ne.sv
// Purpose: far-end element feeding both members of each 1+1 group
// Assumes: fault inputs driven by the bench at mclk edges
// Notes: a broken member carries inverted data, never a kind copy
`timescale 1ns/1ns
module far_end_ne #(
  parameter int TRIB_W = 63
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [1:0] los,
  input wire logic [1:0] ais_up,
  input wire logic [1:0] sect_bad,
  output logic [1:0] conn_rx_in,
  output protsw_pkg::conn_alarm_s conn_alarm_a,
  output protsw_pkg::conn_alarm_s conn_alarm_b,
  output logic [TRIB_W-1:0] sect_trib_a,
  output logic [TRIB_W-1:0] sect_trib_b
);
  logic [TRIB_W-1:0] pat_reg;
  // ==========================================================
  // traffic source, new value every cycle so stale data shows
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pat_reg <= '0;
    end else begin
      pat_reg <= {pat_reg[TRIB_W-2:0], ~pat_reg[TRIB_W-1]};
    end
  end
  // ==========================================================
  // permanent bridge onto exactly two members; faults invert
  assign conn_rx_in[0] = (los[0] | ais_up[0]) ^ pat_reg[0];
  assign conn_rx_in[1] = (los[1] | ais_up[1]) ^ pat_reg[0];
  assign sect_trib_a = sect_bad[0] ? ~pat_reg : pat_reg;
  assign sect_trib_b = sect_bad[1] ? ~pat_reg : pat_reg;
  // upstream failure passed on as alarm indication
  assign conn_alarm_a = '{los: los[0], ais: ais_up[0]};
  assign conn_alarm_b = '{los: los[1], ais: ais_up[1]};
endmodule : far_end_ne

//--- verif/tdm_one_plus_one_protection_switch_tb.sv
// Purpose: register-driven tests of the 1+1 protection selector
// Assumes: short degrade window of 16 cycles
// Notes: expected active members tracked in ca and sa
`timescale 1ns/1ns
`include "protsw_defines.svh"
module tdm_one_plus_one_protection_switch_tb;
  logic mclk = 1'b0;
  logic rst_n;
  protsw_pkg::reg_req_s req;
  logic [31:0] rd_data;
  logic [1:0] los, ais, bip, rxq, ctx_o, stx_o, bus, crx_i;
  logic ctx = 1'b0;
  logic stx = 1'b0;
  logic txq, stxq, crx_o, ca, sa;
  protsw_pkg::sect_alarm_s sal_a, sal_b;
  protsw_pkg::conn_alarm_s cal_a, cal_b;
  protsw_pkg::member_e c_act, s_act;
  logic [62:0] tra, trb, traq, trbq, trib_o;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  // ==========================================================
  // clock, history of inputs, hang guard
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    ctx <= ~ctx;
    stx <= ctx;
    txq <= ctx;
    stxq <= stx;
    rxq <= crx_i;
    traq <= tra;
    trbq <= trb;
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  far_end_ne far (.mclk(mclk), .rst_n(rst_n), .los(los), .ais_up(ais),
    .sect_bad({|sal_b, |sal_a}), .conn_rx_in(crx_i), .conn_alarm_a(cal_a),
    .conn_alarm_b(cal_b), .sect_trib_a(tra), .sect_trib_b(trb));
  protection_switch #(.DEG_WINDOW_CYC(16)) dut (.mclk(mclk),
    .rst_n(rst_n), .reg_req(req), .rd_data(rd_data),
    .conn_alarm_a(cal_a), .conn_alarm_b(cal_b),
    .conn_rx_in(crx_i), .conn_tx_in(ctx), .conn_tx_out(ctx_o),
    .conn_rx_out(crx_o), .conn_active(c_act), .sect_alarm_a(sal_a),
    .sect_alarm_b(sal_b), .sect_bip_err(bip), .sect_trib_a(tra),
    .sect_trib_b(trb), .sect_trib_out(trib_o), .sect_tx_in(stx),
    .sect_tx_out(stx_o), .sect_active(s_act),
    .unit_intercommunication_bus(bus));
  // ==========================================================
  // compare, bus and wait tasks
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input string nm, input logic [7:0] a,
      input logic [31:0] m, input logic [31:0] e);
    @(posedge mclk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1;
    chk(nm, e & m, rd_data & m);
  endtask : rd_chk
  task automatic settle();
    repeat (4) @(posedge mclk);
  endtask : settle
  // selection, bridging and backplane view in one go
  task automatic chk_state(input string nm);
    @(posedge mclk);
    #1;
    chk({nm, " conn_act"}, {31'h0, ca}, {31'h0, c_act});
    chk({nm, " sect_act"}, {31'h0, sa}, {31'h0, s_act});
    chk({nm, " conn_rx"}, {31'h0, rxq[ca]}, {31'h0, crx_o});
    chk({nm, " trib"}, 32'h0, {31'h0, trib_o !== (sa ? trbq : traq)});
    chk({nm, " bus"}, {31'h0, sa}, {31'h0, bus[0]});
    chk({nm, " bus_fail"}, {31'h0, |(sa ? sal_b : sal_a)}, {31'h0, bus[1]});
    chk({nm, " ctx"}, {30'h0, {2{txq}}}, {30'h0, ctx_o});
    chk({nm, " stx"}, {30'h0, {2{stxq}}}, {30'h0, stx_o});
  endtask : chk_state
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0; req = '0; los = '0; ais = '0; bip = '0;
    sal_a = '0; sal_b = '0; ca = 1'b0; sa = 1'b0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    rd_chk("ctrl", `OFS_CTRL, 32'hffffffff, 32'h3);
    rd_chk("thr", `OFS_DEG_THR, 32'hffffffff, 32'h10);
    rd_chk("status", `OFS_STATUS, 32'hffffffff, 32'h0);
    rd_chk("cmd", `OFS_CMD, 32'hffffffff, 32'h0);
    rd_chk("unmapped", 8'h14, 32'hffffffff, 32'h0);
    chk_state("reset");
    // connection: loss, recovery, alarm indication, double fault
    @(posedge mclk) los <= 2'b01;
    ca = 1'b1; settle(); chk_state("conn los");
    rd_chk("conn evt", `OFS_EVENT, 32'h1, 32'h1);
    @(posedge mclk) los <= 2'b00;
    settle(); chk_state("conn back");
    @(posedge mclk) ais <= 2'b10;
    ca = 1'b0; settle(); chk_state("conn ais");
    @(posedge mclk) ais <= 2'b00;
    @(posedge mclk) los <= 2'b11;
    settle(); chk_state("conn both");
    @(posedge mclk) los <= 2'b00;
    // section: each failure kind on the active unit
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      if (sa) sal_b <= 5'h10 >> i; else sal_a <= 5'h10 >> i;
      sa = ~sa; settle(); chk_state("sect fail");
      @(posedge mclk) sal_a <= '0;
      sal_b <= '0;
      settle(); chk_state("sect clear");
    end
    // section degrade from parity errors on the active unit
    wr(`OFS_DEG_THR, 32'h4);
    for (int i = 0; i < 40; i++) begin
      @(posedge mclk) bip <= i[0] ? 2'b00 : {sa, ~sa};
    end
    @(posedge mclk) bip <= 2'b00;
    sa = ~sa; repeat (40) @(posedge mclk);
    chk_state("sect degrade");
    // management request refused while the passive is alarmed
    wr(`OFS_EVENT, 32'hf);
    @(posedge mclk) los <= {~ca, ca};
    if (sa) sal_a <= 5'h08; else sal_b <= 5'h08;
    settle(); wr(`OFS_CMD, 32'h3); settle();
    chk_state("refused");
    rd_chk("refuse evt", `OFS_EVENT, 32'hf, 32'hc);
    @(posedge mclk) los <= 2'b00;
    sal_a <= '0; sal_b <= '0;
    settle(); wr(`OFS_EVENT, 32'hf);
    rd_chk("evt clr", `OFS_EVENT, 32'hf, 32'h0);
    wr(`OFS_CMD, 32'h3);
    ca = ~ca; sa = ~sa; settle(); chk_state("granted");
    rd_chk("grant evt", `OFS_EVENT, 32'hf, 32'h3);
    rd_chk("status", `OFS_STATUS, 32'h3, {30'h0, sa, ca});
    // manual mode: faults ignored, command always obeyed
    wr(`OFS_CTRL, 32'h0);
    @(posedge mclk) los <= 2'b11;
    sal_a <= 5'h01; sal_b <= 5'h02;
    settle(); chk_state("manual hold");
    rd_chk("status f", `OFS_STATUS, 32'hff, {24'h0, 6'h0f, sa, ca});
    wr(`OFS_CMD, 32'h3);
    ca = ~ca; sa = ~sa; settle(); chk_state("manual cmd");
    stop_test();
  end
endmodule : tdm_one_plus_one_protection_switch_tb
